// ==== shared/gbus_defs.svh ====
/*
 * Width, sizing and reset constants for the global expansion bus burst link.
 * Assumes inclusion by bare name from the shared folder.
 */
`ifndef GBUS_DEFS_SVH
`define GBUS_DEFS_SVH

// Data word width of the link
`define GBUS_DATA_W 32
// Width of the transfer size field
`define GBUS_SIZE_W 16
// Words per bridge page
`define GBUS_PAGE_WORDS 256
// Words per dma buffer
`define GBUS_BUF_WORDS 256
// Reset value of the word counters
`define GBUS_CNT_RST 16'h0000

`endif

// ==== shared/gbus_pkg.sv ====
/*
 * Types shared by both ends of the global bus burst link.
 * Assumes gbus_defs.svh is on the include path.
 */
`include "gbus_defs.svh"

package gbus_pkg;
	// Transfer direction seen from the module
	typedef enum logic {
		DIR_READ,
		DIR_WRITE
	} dir_e;
	// One data word
	typedef logic [`GBUS_DATA_W-1:0] word_t;
	// Word count
	typedef logic [`GBUS_SIZE_W-1:0] size_t;
endpackage

// ==== shared/gbus_if.sv ====
/*
 * Link between the module end and the carrier end of the global bus.
 * Assumes both ends share clk_i; the testbench drives the clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface gbus_if;
	logic start;              // Transfer start pulse
	gbus_pkg::dir_e dir;      // Direction of transfer
	gbus_pkg::size_t size;    // Words in transfer
	logic wr_valid;           // Module to carrier word valid
	gbus_pkg::word_t wr_data; // Module to carrier word
	logic wr_ready;           // Carrier accepts word
	logic rd_valid;           // Carrier to module word valid
	gbus_pkg::word_t rd_data; // Carrier to module word
	logic rd_ready;           // Module accepts word
	logic burst;              // Transfer runs as a burst

	// Module end
	modport module_end (
		output start, dir, size, wr_valid, wr_data, rd_ready, burst,
		input wr_ready, rd_valid, rd_data
	);
	// Carrier end
	modport carrier_end (
		input start, dir, size, wr_valid, wr_data, rd_ready, burst,
		output wr_ready, rd_valid, rd_data
	);
endinterface

`default_nettype wire

// ==== design/gbus_module_end.sv ====
/*
 * Module end of the global bus: double buffered burst mover.
 * Holds the transfer sequencer, a two entry word buffer shared by
 * both directions, and the word counters that close a transfer.
 * Assumes one clock with the carrier; user side is a word stream.
 * Assumes go_i comes from logic on clk_i, so it is not synchronised.
 * Assumes the carrier end keeps the same valid and ready rules.
 */
`timescale 1ns/100ps
`default_nettype none

`include "gbus_defs.svh"

module gbus_module_end (
	input wire logic clk_i,
	input wire logic rst_n_i,
	gbus_if.module_end bus,
	input wire logic go_i,
	input wire gbus_pkg::dir_e dir_i,
	input wire gbus_pkg::size_t size_i,
	input wire logic in_valid_i,
	input wire gbus_pkg::word_t in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output gbus_pkg::word_t out_data_o,
	input wire logic out_ready_i,
	output logic busy_o,
	output logic done_o
);
	// ==========================================================
	// Transfer control
	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN
	} state_e;

	state_e state_r;
	gbus_pkg::dir_e dir_r;     // Latched direction
	gbus_pkg::size_t left_r;   // Words still to move
	logic start_r;             // Start pulse to carrier
	logic burst_r;             // Burst flag to carrier
	logic done_r;              // Completion pulse
	logic busy_r; // Transfer in progress
	gbus_pkg::size_t fill_left_r; // Words still to enter buffer

	// Two entry buffer, shared by both directions
	gbus_pkg::word_t buf_r [0:1];
	logic [1:0] cnt_r;         // Entries held
	logic wp_r;                // Write slot
	logic rp_r;                // Read slot

	wire fill_v;               // Word offered to buffer
	wire gbus_pkg::word_t fill_d;
	wire drain; // Drain side ready
	wire fill_more; // Transfer still wants words
	wire can_fill;
	wire has_word;
	wire push;
	wire pop;
	wire running;

	// ==========================================================
	// Buffer handshakes
	// ==========================================================
	// Occupancy and sequencer state
	assign running = (state_r == ST_RUN);
	assign can_fill = (cnt_r != 2'h2);
	assign has_word = (cnt_r != 2'h0);
	// Stops fetching once the whole size has entered the buffer
	assign fill_more = (fill_left_r != `GBUS_CNT_RST);
	// Write: user fills, bus drains; read: bus fills, user drains
	assign fill_v = running && ((dir_r == gbus_pkg::DIR_WRITE) ?
		in_valid_i : bus.rd_valid);
	assign fill_d = (dir_r == gbus_pkg::DIR_WRITE) ? in_data_i :
		bus.rd_data;
	// Drain side ready select
	assign drain = (dir_r == gbus_pkg::DIR_WRITE) ? bus.wr_ready :
		out_ready_i;
	// Handshakes; a fill and a drain together keep the flow going
	assign push = fill_v && can_fill && fill_more;
	assign pop = has_word && drain;

	// ==========================================================
	// Port views
	// ==========================================================
	// User write stream ready
	assign in_ready_o = running && dir_r == gbus_pkg::DIR_WRITE &&
		can_fill && fill_more;
	// Prefetch from the carrier while the user drains the other entry
	assign bus.rd_ready = running && dir_r == gbus_pkg::DIR_READ &&
		can_fill && fill_more;
	// Module to carrier words
	assign bus.wr_valid = dir_r == gbus_pkg::DIR_WRITE && has_word;
	assign bus.wr_data = buf_r[rp_r];
	// Carrier to user words
	assign out_valid_o = dir_r == gbus_pkg::DIR_READ && has_word;
	assign out_data_o = buf_r[rp_r];
	// Transfer control towards the carrier
	assign bus.start = start_r;
	assign bus.dir = dir_r;
	assign bus.size = left_r;
	assign bus.burst = burst_r;
	// Transfer status towards the user
	assign busy_o = busy_r;
	assign done_o = done_r;

	// ==========================================================
	// Buffer storage and pointers
	// ==========================================================
	// One word register per entry, loaded when it is the write slot
	for (genvar e = 0; e < 2; e++) begin : g_entry
		always_ff @(posedge clk_i) begin
			if (push && wp_r == 1'(e)) begin
				buf_r[e] <= fill_d;
			end
		end
	end

	// Buffer pointers; a push and pop together keep one word per clock
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Empty buffer, both slots at zero
			cnt_r <= 2'h0;
			wp_r <= 1'b0;
			rp_r <= 1'b0;
		end else begin
			// Each slot pointer toggles on its own handshake
			if (push) begin
				wp_r <= ~wp_r;
			end
			if (pop) begin
				rp_r <= ~rp_r;
			end
			// Occupancy follows both handshakes
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// ==========================================================
	// Word counting
	// ==========================================================
	// Fill counter: words still to enter the buffer this transfer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fill_left_r <= `GBUS_CNT_RST;
		end else if (state_r == ST_IDLE && go_i) begin
			// Loaded with the size as the transfer is taken
			fill_left_r <= size_i;
		end else if (push) begin
			fill_left_r <= fill_left_r - 16'h0001;
		end
	end

	// Sequencer: counts words that leave the buffer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Idle, nothing owed to either side
			state_r <= ST_IDLE;
			dir_r <= gbus_pkg::DIR_READ;
			left_r <= `GBUS_CNT_RST;
			start_r <= 1'b0;
			burst_r <= 1'b0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			// Pulses stand for one cycle
			start_r <= 1'b0;
			done_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					// Direction latched on the same edge that raises start, as software sets it
					// Size zero is refused and the block stays idle
					if (go_i && size_i != `GBUS_CNT_RST) begin
						dir_r <= dir_i;
						left_r <= size_i;
						start_r <= 1'b1;
						burst_r <= (size_i > 16'h0001);
						state_r <= ST_RUN;
						busy_r <= 1'b1;
					end
				end
				ST_RUN: begin
					// Each word that leaves the buffer counts once
					if (pop) begin
						left_r <= left_r - 16'h0001;
						if (left_r == 16'h0001) begin
							// Last word has left: close the transfer
							done_r <= 1'b1;
							burst_r <= 1'b0;
							state_r <= ST_IDLE;
							busy_r <= 1'b0;
						end
					end
				end
				// Illegal state code returns to idle
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // gbus_module_end

`default_nettype wire

// ==== design/gbus_carrier_end.sv ====
/*
 * Carrier end of the global bus: bridge page memory model side logic.
 * Assumes one clock with the module end; user side is a page address.
 */
`timescale 1ns/100ps
`default_nettype none

`include "gbus_defs.svh"

module gbus_carrier_end #(
	parameter int PAGE_WORDS = `GBUS_PAGE_WORDS
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	gbus_if.carrier_end bus,
	input wire logic [31:0] base_i,
	input wire logic stall_i,
	output logic [31:0] addr_o,
	output logic wr_o,
	output logic [31:0] wdata_o,
	output logic crossed_o
);
	// ==========================================================
	// Page addressed word store
	// ==========================================================
	localparam int AW = $clog2(PAGE_WORDS);
	gbus_pkg::word_t mem_r [0:PAGE_WORDS-1];
	logic [31:0] addr_r;       // Current byte address
	logic [31:0] page_r;       // Page base of burst
	logic wr_r;
	logic [31:0] wdata_r;
	logic crossed_r;
	wire [AW-1:0] idx;
	wire [31:0] next_addr;
	wire take;

	assign idx = addr_r[AW+1:2];
	// Overrun wraps inside the page, as the bridge does
	assign next_addr = page_r | {{(30-AW){1'b0}},
		AW'(idx + AW'(1)), 2'b00};
	assign take = bus.wr_valid && !stall_i;
	assign bus.wr_ready = !stall_i;
	// No word offered while the new start address loads
	assign bus.rd_valid = !stall_i && !bus.start;
	assign bus.rd_data = mem_r[idx];
	assign addr_o = addr_r;
	assign wr_o = wr_r;
	assign wdata_o = wdata_r;
	assign crossed_o = crossed_r;

	// Store written words
	always_ff @(posedge clk_i) begin
		if (take) begin
			mem_r[idx] <= bus.wr_data;
		end
	end

	// Address walk; wrap flagged as a page crossing
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_r <= 32'h00000000;
			page_r <= 32'h00000000;
			wr_r <= 1'b0;
			wdata_r <= 32'h00000000;
			crossed_r <= 1'b0;
		end else begin
			wr_r <= take;
			wdata_r <= bus.wr_data;
			if (bus.start) begin
				addr_r <= base_i;
				page_r <= base_i & ~32'(PAGE_WORDS * 4 - 1);
				crossed_r <= 1'b0;
			end else if (take || (bus.rd_ready && !stall_i)) begin
				addr_r <= next_addr;
				if (idx == AW'(PAGE_WORDS - 1)) begin
					crossed_r <= 1'b1;
				end
			end
		end
	end
endmodule // gbus_carrier_end

`default_nettype wire

// ==== sim/gbus_asserts.sv ====
/* Checker on the link between module end and carrier end.
   Assumes the bench instantiates it beside the interface. */
`timescale 1ns/100ps
`default_nettype none
module gbus_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start,
	input wire gbus_pkg::dir_e dir,
	input wire gbus_pkg::size_t size,
	input wire logic burst,
	input wire logic wr_valid,
	input wire gbus_pkg::word_t wr_data,
	input wire logic wr_ready,
	input wire logic rd_ready
);
	// ========
	// Write word counter
	gbus_pkg::size_t cnt_r; // Words sent
	gbus_pkg::size_t tot_r; // Words asked
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 16'h0000;
			tot_r <= 16'h0000;
		end else if (start) begin
			cnt_r <= 16'h0000;
			tot_r <= size;
		end else if (wr_valid && wr_ready) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ========
	// Properties
	property p_burst_on;
		start && size > 16'h0001 |-> ##[0:1] burst;
	endproperty
	a_burst_on: assert property (p_burst_on) else $error("no burst");
	property p_single;
		start && size == 16'h0001 |=> !burst;
	endproperty
	a_single: assert property (p_single) else $error("single burst");
	property p_hold;
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_data);
	endproperty
	a_hold: assert property (p_hold) else $error("word dropped");
	property p_prefetch;
		start && dir == gbus_pkg::DIR_READ |-> ##[1:3] rd_ready;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("no fetch");
	property p_count;
		wr_valid && wr_ready |-> cnt_r < tot_r;
	endproperty
	a_count: assert property (p_count) else $error("too many");
	property p_start_pulse;
		start |=> !start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start");
	property p_burst_end;
		burst && wr_valid && wr_ready && cnt_r == tot_r - 16'h0001
			|=> !burst;
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst");
	cover property (start && dir == gbus_pkg::DIR_WRITE);
	cover property (start && dir == gbus_pkg::DIR_READ);
	cover property (wr_valid && !wr_ready);
endmodule // gbus_asserts
`default_nettype wire

// ==== sim/tb_global_bus_burst_interface.sv ====
/* Bench for both link ends joined by one interface.
   Assumes the shared package and interface are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_global_bus_burst_interface;
	logic clk_i;
	logic rst_n_i;
	logic go_i;
	gbus_pkg::dir_e dir_i;
	gbus_pkg::size_t size_i;
	logic in_valid_i;
	gbus_pkg::word_t in_data_i;
	logic in_ready_o;
	logic out_valid_o;
	gbus_pkg::word_t out_data_o;
	logic out_ready_i;
	logic busy_o;
	logic done_o;
	logic [31:0] base_i;
	logic stall_i;
	logic wr_o;
	logic [31:0] wdata_o;
	logic [31:0] addr_o;
	logic crossed_o;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int n_in = 0;
	int nw = 0;
	int n_wr = 0;
	int n_rd = 0;
	int t0 = 0;
	int t1 = 0;
	logic stall_en = 1'b0; // Far side and reader stall
	gbus_if g ();
	gbus_module_end gbus_module_end_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus(g), .go_i(go_i), .dir_i(dir_i), .size_i(size_i),
		.in_valid_i(in_valid_i), .in_data_i(in_data_i),
		.in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
		.out_data_o(out_data_o), .out_ready_i(out_ready_i),
		.busy_o(busy_o), .done_o(done_o));
	gbus_carrier_end gbus_carrier_end_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus(g), .base_i(base_i), .stall_i(stall_i), .addr_o(addr_o),
		.wr_o(wr_o), .wdata_o(wdata_o), .crossed_o(crossed_o));
	gbus_asserts gbus_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.start(g.start), .dir(g.dir), .size(g.size), .burst(g.burst),
		.wr_valid(g.wr_valid), .wr_data(g.wr_data),
		.wr_ready(g.wr_ready), .rd_ready(g.rd_ready));
	// ========
	// Tasks
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic xfer(input gbus_pkg::dir_e d, input logic [31:0] b,
		input gbus_pkg::size_t n);
		int k;
		@(negedge clk_i);
		n_wr = 0;
		n_rd = 0;
		n_in = 0;
		nw = (d == gbus_pkg::DIR_WRITE) ? int'(n) : 0;
		dir_i = d;
		size_i = n;
		base_i = b;
		@(negedge clk_i);
		go_i = 1'b1;
		@(negedge clk_i);
		go_i = 1'b0;
		k = 0;
		while (done_o !== 1'b1 && k < 2000) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		repeat (2) @(negedge clk_i);
		check(32'(k < 2000), 32'h1);
		check(32'(n_wr + n_rd), 32'(n));
		check(32'(busy_o), 32'h0);
	endtask
	// ========
	// Clock, monitor and drivers
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (in_valid_i && in_ready_o) n_in++;
		if (out_valid_o && out_ready_i) begin
			check(out_data_o, 32'hA5000000 + 32'(n_rd));
			n_rd++;
		end
		if (wr_o) begin
			if (n_wr == 0) t0 = cyc;
			t1 = cyc;
			check(wdata_o, 32'hA5000000 + 32'(n_wr));
			n_wr++;
		end
		if (cyc > 5000) begin
			n_errors++;
			final_report();
		end
	end
	always @(negedge clk_i) begin
		in_data_i = 32'hA5000000 + 32'(n_in);
		in_valid_i = rst_n_i && n_in < nw;
		stall_i = stall_en & cyc[1];
		out_ready_i = !(stall_en & cyc[2]);
	end
	// ========
	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		go_i = 1'b0;
		dir_i = gbus_pkg::DIR_READ;
		size_i = 16'h0000;
		base_i = 32'h00000000;
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		xfer(gbus_pkg::DIR_WRITE, 32'h00000100, 16'h0008);
		check(32'(t1 - t0), 32'h7);
		xfer(gbus_pkg::DIR_WRITE, 32'h00000200, 16'h0001);
		xfer(gbus_pkg::DIR_READ, 32'h00000100, 16'h0008);
		stall_en = 1'b1;
		xfer(gbus_pkg::DIR_WRITE, 32'h00000000, 16'h000C);
		xfer(gbus_pkg::DIR_READ, 32'h00000000, 16'h000C);
		stall_en = 1'b0;
		check(32'(crossed_o), 32'h0);
		xfer(gbus_pkg::DIR_WRITE, 32'h000003F8, 16'h0004);
		check(32'(crossed_o), 32'h1);
		check(addr_o, 32'h00000008);
		final_report();
	end
endmodule // tb_global_bus_burst_interface
`default_nettype wire
